//--- acs_pkg.sv
// Purpose: shared constants for the conversion sequencer and its bus master
// Assumes: 250 MHz CLOCK, two-wire bus with open-drain data line
// Notes: long cycle counts are defaults for top-level parameters
//
// Operation
// - Acked write plus STOP restarts, drops result
// - Config byte in write applies to that conversion
// - Acknowledge global address 1110111 besides own
// - Master waits until all converters finished
// - Global STOP loads config, starts conversion together
// - Write aborted before byte keeps old configuration
// - Rejection defaults to dual mains after reset
// - Toggling address pin selects external clock
// - External clock makes low address bit high
// - Detector needs external clock of 10 kHz
// - No external clock enables internal oscillator
// - Source change spoils only current conversion
// - 60 Hz: 133 ms, 67 ms double speed
// - 50 Hz: 160 ms, 80 ms double speed
// - Dual rejection: 147 ms, 73.6 ms
// - External: 41036 or 20556 clock periods
// - External notch at clock over 5120
// - Power-on reset of 4 ms clears registers
// - After power-on reset convert without command
// - Calibration hidden inside every conversion
// - One settled result per conversion
// - After conversion sleep, ready for transactions
// - Busy device does not acknowledge address
package acs_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TMR_W = 26;
  // ----------------------------------------
  // Conversion and reset times
  // ----------------------------------------
  localparam int unsigned POR_US = 4000;
  localparam int unsigned T60_N_US = 133000;
  localparam int unsigned T60_D_US = 67000;
  localparam int unsigned T50_N_US = 160000;
  localparam int unsigned T50_D_US = 80000;
  localparam int unsigned TDU_N_US = 147000;
  localparam int unsigned TDU_D_US = 73600;
  localparam int unsigned POR_CYC = POR_US * CLK_MHZ;
  localparam int unsigned T60_N_CYC = T60_N_US * CLK_MHZ;
  localparam int unsigned T60_D_CYC = T60_D_US * CLK_MHZ;
  localparam int unsigned T50_N_CYC = T50_N_US * CLK_MHZ;
  localparam int unsigned T50_D_CYC = T50_D_US * CLK_MHZ;
  localparam int unsigned TDU_N_CYC = TDU_N_US * CLK_MHZ;
  localparam int unsigned TDU_D_CYC = TDU_D_US * CLK_MHZ;
  localparam int unsigned EXT_N_PER = 41036;
  localparam int unsigned EXT_D_PER = 20556;
  localparam int unsigned EXT_NOTCH_DIV = 5120;
  localparam int unsigned EXT_MIN_HZ = 10000;
  localparam int unsigned EXT_TMO_CYC = CLK_MHZ * 1000000 / EXT_MIN_HZ;
  // ----------------------------------------
  // Bus addressing and configuration byte
  // ----------------------------------------
  localparam logic [6:0] GLOBAL_ADDR = 7'h77;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int unsigned CFG_REJ_LSB = 0;
  localparam int unsigned CFG_SPEED_BIT = 2;
  localparam logic [1:0] REJ_DUAL = 2'h0;
  localparam logic [1:0] REJ_50 = 2'h1;
  localparam logic [1:0] REJ_60 = 2'h2;
  // ----------------------------------------
  // Master registers and bit timing
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_GLOBAL = 1;
  localparam int unsigned CTRL_SEND_CFG = 2;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_NACK = 1;
  localparam int unsigned STAT_DONE = 2;
  localparam int unsigned BUS_KHZ = 100;
  localparam int unsigned QTR_CYC = CLK_MHZ * 1000 / (BUS_KHZ * 4);
  localparam logic [9:0] QTR_LAST = 10'(QTR_CYC - 1);
endpackage

//--- acs_if.sv
// Purpose: two-wire link between converter sequencer and bus master
// Assumes: master alone drives the clock line
// Notes: data line resolved as wired-AND of both open-drain drivers
`timescale 1ns/1ns
`default_nettype none
interface acs_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic sda;
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
  modport master (output scl, output sda_m_o, output sda_m_oe_n, input sda);
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe_n);
endinterface
`default_nettype wire

//--- acs_master.sv
// Purpose: bus master issuing address and optional configuration writes
// Assumes: software polls status; no clock stretching by the slave
// Notes: reads from the converter are not issued
`timescale 1ns/1ns
`default_nettype none
module acs_master (
  input wire logic CLOCK,
  input wire logic NRST,
  acs_if.master LINK,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);
  import acs_pkg::*;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BIT = 3'b010,
    H_STOP = 3'b011
  } acs_hst_e;
  acs_hst_e st_q;
  logic [9:0] div_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [6:0] target_q;
  logic [7:0] cfg_q;
  logic global_q, send_cfg_q, byte_q, ack_ok_q;
  logic busy_q, nack_q, done_q, scl_q, oe_n_q;
  logic tick, go;
  assign tick = (div_q == QTR_LAST);
  assign go = WR && (ADDR == REG_CTRL) && WDATA[CTRL_GO] && !busy_q;
  assign LINK.scl = scl_q;
  assign LINK.sda_m_o = 1'b0;
  assign LINK.sda_m_oe_n = oe_n_q;
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      target_q <= 7'h00;
      cfg_q <= CFG_RESET;
      global_q <= 1'b0;
      send_cfg_q <= 1'b0;
    end else if (WR && !busy_q) begin
      if (ADDR == REG_TARGET) target_q <= WDATA[6:0];
      if (ADDR == REG_CFG) cfg_q <= WDATA[7:0];
      if (ADDR == REG_CTRL) begin
        global_q <= WDATA[CTRL_GLOBAL];
        send_cfg_q <= WDATA[CTRL_SEND_CFG];
      end
    end
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        REG_CTRL: RDATA <= {29'h0000_0000, send_cfg_q, global_q, 1'b0};
        REG_TARGET: RDATA <= {25'h000_0000, target_q};
        REG_CFG: RDATA <= {24'h00_0000, cfg_q};
        REG_STAT: RDATA <= {29'h0000_0000, done_q, nack_q, busy_q};
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // Quarter-bit divider
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) div_q <= 10'h000;
    else if (st_q == H_IDLE || tick) div_q <= 10'h000;
    else div_q <= div_q + 10'h001;
  end
  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q <= H_IDLE;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      byte_q <= 1'b0;
      ack_ok_q <= 1'b0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      scl_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (go) begin
            st_q <= H_START;
            qtr_q <= 2'h0;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            done_q <= 1'b0;
            byte_q <= 1'b0;
            tx_q <= {(WDATA[CTRL_GLOBAL] ? GLOBAL_ADDR : target_q), 1'b0};
          end
        end
        H_START: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h1) oe_n_q <= 1'b0;
          if (qtr_q == 2'h2) begin
            scl_q <= 1'b0;
            st_q <= H_BIT;
            qtr_q <= 2'h0;
            bit_q <= 4'h0;
          end
        end
        H_BIT: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          case (qtr_q)
            2'h0: oe_n_q <= (bit_q == 4'h8) || tx_q[7];
            2'h1: scl_q <= 1'b1;
            2'h2: if (bit_q == 4'h8) ack_ok_q <= !LINK.sda;
            default: begin
              scl_q <= 1'b0;
              if (bit_q != 4'h8) begin
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end else if (ack_ok_q && !byte_q && send_cfg_q) begin
                byte_q <= 1'b1;
                tx_q <= cfg_q;
                bit_q <= 4'h0;
              end else begin
                // A refused address means the converter is still busy
                nack_q <= !ack_ok_q;
                st_q <= H_STOP;
              end
            end
          endcase
        end
        H_STOP: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          case (qtr_q)
            2'h0: oe_n_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_n_q <= 1'b1;
            default: begin
              st_q <= H_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          endcase
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- acs_sequencer.sv
// Purpose: converter-side bus slave, clock source selection and conversion timing
// Assumes: bus pins and address pin arrive asynchronously
// Notes: analog front end, filter and result data are outside this block
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer #(
  parameter int unsigned POR_CYCLES = acs_pkg::POR_CYC,
  parameter int unsigned T60_N_CYCLES = acs_pkg::T60_N_CYC,
  parameter int unsigned T60_D_CYCLES = acs_pkg::T60_D_CYC,
  parameter int unsigned T50_N_CYCLES = acs_pkg::T50_N_CYC,
  parameter int unsigned T50_D_CYCLES = acs_pkg::T50_D_CYC,
  parameter int unsigned TDU_N_CYCLES = acs_pkg::TDU_N_CYC,
  parameter int unsigned TDU_D_CYCLES = acs_pkg::TDU_D_CYC,
  parameter int unsigned EXT_TMO_CYCLES = acs_pkg::EXT_TMO_CYC
) (
  input wire logic CLOCK,
  input wire logic NRST,
  acs_if.slave LINK,
  input wire logic [5:0] ADDR_HI_PINS,
  input wire logic ADDR_OR_CONV_CLOCK_PIN,
  output logic POR_ACTIVE,
  output logic CONVERTING,
  output logic CONV_DONE,
  output logic RESULT_VALID,
  output logic RESULT_SUSPECT,
  output logic INT_OSC_EN,
  output logic EXT_CLK_ACTIVE,
  output logic NOTCH_EXT,
  output logic [7:0] CFG_ACTIVE
);
  import acs_pkg::*;
  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_CONV = 2'b01,
    ST_SLEEP = 2'b10,
    ST_IO = 2'b11
  } acs_st_e;
  acs_st_e st_q;
  logic [8:0] s1_q, s2_q;
  logic scl_p_q, sda_p_q, ext_p_q;
  logic scl, sda, ext, low_address_select_pin;
  logic start_c, stop_c, rise, fall, ext_edge;
  logic [TMR_W-1:0] det_q, tmr_q, por_q;
  logic ext_present_q, src_ext_q;
  logic [7:0] sh_q, cfg_rx_q;
  logic [3:0] bit_q;
  logic act_q, first_q, sel_q, got_cfg_q, drive_q;
  logic [6:0] own_addr;
  logic addr_hit, addr_ack_ev, cfg_ev, cfg_ev_n;
  logic [7:0] cfg_use;
  // ----------------------------------------
  // Input synchronisers and bus events
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s1_q <= 9'h1FF;
      s2_q <= 9'h1FF;
    end else begin
      s1_q <= {ADDR_HI_PINS, ADDR_OR_CONV_CLOCK_PIN, LINK.scl, LINK.sda};
      s2_q <= s1_q;
    end
  end
  assign sda = s2_q[0];
  assign scl = s2_q[1];
  assign ext = s2_q[2];
  assign low_address_select_pin = s2_q[2];
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      // Matches synchroniser reset level, so no false edge after reset
      ext_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      ext_p_q <= ext;
    end
  end
  assign start_c = scl && scl_p_q && sda_p_q && !sda;
  assign stop_c = scl && scl_p_q && !sda_p_q && sda;
  assign rise = scl && !scl_p_q;
  assign fall = !scl && scl_p_q;
  assign ext_edge = ext && !ext_p_q;
  // ----------------------------------------
  // External clock detector
  // ----------------------------------------
  // Two rising edges closer than the slowest legal period mean a clock
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      det_q <= TMR_W'(EXT_TMO_CYCLES);
      ext_present_q <= 1'b0;
    end else if (ext_edge) begin
      det_q <= '0;
      ext_present_q <= (det_q < TMR_W'(EXT_TMO_CYCLES));
    end else if (det_q < TMR_W'(EXT_TMO_CYCLES)) begin
      det_q <= det_q + 1'b1;
    end else begin
      ext_present_q <= 1'b0;
    end
  end
  assign own_addr = {s2_q[8:3], ext_present_q | low_address_select_pin};
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign addr_hit = (sh_q[7:1] == own_addr) || (sh_q[7:1] == GLOBAL_ADDR);
  // Busy or not sleeping: leave the address unacknowledged
  assign addr_ack_ev = fall && act_q && first_q && (bit_q == 4'h8) && addr_hit && !sh_q[0]
                       && (st_q == ST_SLEEP);
  assign cfg_ev = fall && act_q && !first_q && (bit_q == 4'h8) && sel_q;
  assign cfg_ev_n = !cfg_ev;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      act_q <= 1'b0;
      first_q <= 1'b0;
      sel_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (start_c) begin
      act_q <= 1'b1;
      first_q <= 1'b1;
      bit_q <= 4'h0;
      drive_q <= 1'b0;
    end else if (stop_c) begin
      act_q <= 1'b0;
      sel_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (act_q) begin
      if (rise && bit_q != 4'h8) begin
        sh_q <= {sh_q[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end else if (rise) begin
        bit_q <= 4'h0;
        first_q <= 1'b0;
        act_q <= drive_q;
      end else if (fall && bit_q == 4'h8) begin
        drive_q <= addr_ack_ev || !cfg_ev_n;
        if (addr_ack_ev) sel_q <= 1'b1;
      end else if (fall && bit_q == 4'h0) begin
        drive_q <= 1'b0;
      end
    end
  end
  assign LINK.sda_s_o = 1'b0;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) LINK.sda_s_oe_n <= 1'b1;
    else LINK.sda_s_oe_n <= !drive_q;
  end
  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cfg_rx_q <= 8'h00;
      got_cfg_q <= 1'b0;
      CFG_ACTIVE <= CFG_RESET;
    end else if (start_c && !sel_q) begin
      got_cfg_q <= 1'b0;
    end else if (cfg_ev) begin
      cfg_rx_q <= sh_q;
      got_cfg_q <= 1'b1;
    end else if (stop_c && st_q == ST_IO) begin
      if (got_cfg_q) CFG_ACTIVE <= cfg_rx_q;
      got_cfg_q <= 1'b0;
    end
  end
  assign cfg_use = got_cfg_q ? cfg_rx_q : CFG_ACTIVE;
  function automatic logic [TMR_W-1:0] conv_len(input logic [7:0] c, input logic x);
    logic dbl;
    dbl = c[CFG_SPEED_BIT];
    if (x) return TMR_W'(dbl ? EXT_D_PER : EXT_N_PER);
    case (c[CFG_REJ_LSB +: 2])
      REJ_60: return TMR_W'(dbl ? T60_D_CYCLES : T60_N_CYCLES);
      REJ_50: return TMR_W'(dbl ? T50_D_CYCLES : T50_N_CYCLES);
      default: return TMR_W'(dbl ? TDU_D_CYCLES : TDU_N_CYCLES);
    endcase
  endfunction
  // ----------------------------------------
  // Conversion sequence
  // ----------------------------------------
  // Calibration sits inside each timed conversion, so no extra phase
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q <= ST_POR;
      por_q <= '0;
      tmr_q <= '0;
      src_ext_q <= 1'b0;
      CONV_DONE <= 1'b0;
      RESULT_VALID <= 1'b0;
      RESULT_SUSPECT <= 1'b0;
      NOTCH_EXT <= 1'b0;
    end else begin
      CONV_DONE <= 1'b0;
      case (st_q)
        ST_POR: begin
          por_q <= por_q + 1'b1;
          if (por_q == TMR_W'(POR_CYCLES - 1)) begin
            st_q <= ST_CONV;
            tmr_q <= conv_len(CFG_ACTIVE, ext_present_q);
            src_ext_q <= ext_present_q;
          end
        end
        ST_CONV: begin
          if (ext_present_q != src_ext_q) begin
            // Source swap spoils this result only; next start reloads
            st_q <= ST_SLEEP;
            RESULT_SUSPECT <= 1'b1;
            RESULT_VALID <= 1'b1;
            CONV_DONE <= 1'b1;
          end else if (tmr_q == '0) begin
            st_q <= ST_SLEEP;
            RESULT_VALID <= 1'b1;
            CONV_DONE <= 1'b1;
          end else if (!src_ext_q || ext_edge) begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        ST_SLEEP: if (addr_ack_ev) st_q <= ST_IO;
        ST_IO: if (stop_c) begin
          st_q <= ST_CONV;
          tmr_q <= conv_len(cfg_use, ext_present_q);
          src_ext_q <= ext_present_q;
          NOTCH_EXT <= ext_present_q;
          RESULT_VALID <= 1'b0;
          RESULT_SUSPECT <= 1'b0;
        end
        default: st_q <= ST_POR;
      endcase
    end
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      POR_ACTIVE <= 1'b1;
      CONVERTING <= 1'b0;
      INT_OSC_EN <= 1'b1;
      EXT_CLK_ACTIVE <= 1'b0;
    end else begin
      POR_ACTIVE <= (st_q == ST_POR);
      CONVERTING <= (st_q == ST_CONV);
      INT_OSC_EN <= !ext_present_q;
      EXT_CLK_ACTIVE <= ext_present_q;
    end
  end
endmodule
`default_nettype wire

//--- acs_chk_sva.sv
// Purpose: timing and link checks for the converter side of the two-wire link
// Assumes: one clock domain, NRST asynchronous active low
// Notes: internal conversion lengths may exceed the nominal count by up to two cycles
`timescale 1ns/1ns
`default_nettype none
module acs_chk #(
  parameter int unsigned T60_N_CYCLES = acs_pkg::T60_N_CYC,
  parameter int unsigned T60_D_CYCLES = acs_pkg::T60_D_CYC,
  parameter int unsigned T50_N_CYCLES = acs_pkg::T50_N_CYC,
  parameter int unsigned T50_D_CYCLES = acs_pkg::T50_D_CYC,
  parameter int unsigned TDU_N_CYCLES = acs_pkg::TDU_N_CYC,
  parameter int unsigned TDU_D_CYCLES = acs_pkg::TDU_D_CYC
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic scl,
  input wire logic sda_s_oe_n,
  input wire logic POR_ACTIVE,
  input wire logic CONVERTING,
  input wire logic CONV_DONE,
  input wire logic RESULT_VALID,
  input wire logic RESULT_SUSPECT,
  input wire logic INT_OSC_EN,
  input wire logic EXT_CLK_ACTIVE,
  input wire logic NOTCH_EXT,
  input wire logic [7:0] CFG_ACTIVE
);
  logic conv_q;
  logic [31:0] run_q;
  logic [31:0] exp_len;
  // ----------------------------------------
  // Length of the current conversion
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      conv_q <= 1'b0;
      run_q <= 32'h0;
    end else begin
      conv_q <= CONVERTING;
      if (CONVERTING) begin
        run_q <= conv_q ? run_q + 32'h1 : 32'h1;
      end
    end
  end
  always_comb begin
    case (CFG_ACTIVE[1:0])
      2'h1: exp_len = CFG_ACTIVE[2] ? T50_D_CYCLES : T50_N_CYCLES;
      2'h2: exp_len = CFG_ACTIVE[2] ? T60_D_CYCLES : T60_N_CYCLES;
      default: exp_len = CFG_ACTIVE[2] ? TDU_D_CYCLES : TDU_N_CYCLES;
    endcase
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  a_por_idle: assert property (POR_ACTIVE |-> !CONVERTING && sda_s_oe_n)
    else $error("activity during power-on reset");
  a_por_starts: assert property ($fell(POR_ACTIVE) |-> ##[0:4] CONVERTING)
    else $error("no conversion after power-on reset");
  a_busy_no_ack: assert property (CONVERTING |-> sda_s_oe_n)
    else $error("data line driven while converting");
  a_start_drops: assert property ($rose(CONVERTING) |-> !RESULT_VALID)
    else $error("old result kept at conversion start");
  a_done_sleeps: assert property (CONV_DONE |-> ##[1:2] (RESULT_VALID && !CONVERTING))
    else $error("no sleep with result after conversion");
  a_done_once: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("completion pulse longer than one cycle");
  a_osc_excl: assert property (INT_OSC_EN != EXT_CLK_ACTIVE)
    else $error("oscillator enable disagrees with clock source");
  a_cfg_hold: assert property (CONVERTING && $past(CONVERTING) |-> $stable(CFG_ACTIVE))
    else $error("configuration changed inside a conversion");
  a_ack_on_low: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("data line changed while clock high");
  a_suspect_end: assert property ($rose(RESULT_SUSPECT) |-> ##1 !CONVERTING)
    else $error("suspect flag raised inside a conversion");
  a_conv_len: assert property ($fell(CONVERTING) && !NOTCH_EXT && !EXT_CLK_ACTIVE && !RESULT_SUSPECT
    |-> run_q >= exp_len && run_q <= exp_len + 32'h2) else $error("conversion length wrong for mode");
endmodule
`default_nettype wire

//--- adc_conversion_sequencer_tb.sv
// Purpose: drives the bus master's register port and watches the sequencer
// Assumes: shortened conversion counts; one long count keeps the first conversion busy
// Notes: each bus frame costs tens of thousands of cycles, so only a few are run
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  localparam int unsigned T60N = 300;
  localparam int unsigned T60D = 200;
  localparam int unsigned T50N = 400;
  localparam int unsigned T50D = 500;
  localparam int unsigned TDUN = 25000;
  localparam int unsigned TDUD = 700;
  typedef struct {logic [7:0] cfg; int len; logic sus;} acs_note_s;
  logic clock, nrst, wr, rd, ckpin, ext_run, prev_conv;
  logic [7:0] addr, cfg, cfg_active;
  logic [31:0] wdata, rdata, s, run_len;
  logic [5:0] hi;
  logic [4:0] div;
  logic por_active, converting, conv_done, result_valid, result_suspect, int_osc_en, ext_clk_active, notch_ext;
  int n_errors, total_checks;
  acs_note_s notes[$];
  acs_note_s note;
  acs_if link();
  acs_master acs_master_i (.CLOCK(clock), .NRST(nrst), .LINK(link), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata));
  acs_sequencer #(.POR_CYCLES(50), .T60_N_CYCLES(T60N), .T60_D_CYCLES(T60D), .T50_N_CYCLES(T50N),
    .T50_D_CYCLES(T50D), .TDU_N_CYCLES(TDUN), .TDU_D_CYCLES(TDUD), .EXT_TMO_CYCLES(100)) acs_sequencer_i (
    .CLOCK(clock), .NRST(nrst), .LINK(link), .ADDR_HI_PINS(hi), .ADDR_OR_CONV_CLOCK_PIN(ckpin),
    .POR_ACTIVE(por_active), .CONVERTING(converting), .CONV_DONE(conv_done), .RESULT_VALID(result_valid),
    .RESULT_SUSPECT(result_suspect), .INT_OSC_EN(int_osc_en), .EXT_CLK_ACTIVE(ext_clk_active),
    .NOTCH_EXT(notch_ext), .CFG_ACTIVE(cfg_active));
  acs_chk #(.T60_N_CYCLES(T60N), .T60_D_CYCLES(T60D), .T50_N_CYCLES(T50N), .T50_D_CYCLES(T50D),
    .TDU_N_CYCLES(TDUN), .TDU_D_CYCLES(TDUD)) acs_chk_i (.CLOCK(clock), .NRST(nrst), .scl(link.scl),
    .sda_s_oe_n(link.sda_s_oe_n), .POR_ACTIVE(por_active), .CONVERTING(converting), .CONV_DONE(conv_done),
    .RESULT_VALID(result_valid), .RESULT_SUSPECT(result_suspect), .INT_OSC_EN(int_osc_en),
    .EXT_CLK_ACTIVE(ext_clk_active), .NOTCH_EXT(notch_ext), .CFG_ACTIVE(cfg_active));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Polling keeps the strobes busy; the frame itself dominates run time
  task automatic frame(logic [31:0] ctrl, output logic [31:0] st);
    reg_wr(REG_CTRL, ctrl);
    for (int i = 0; i < 40000; i++) begin
      reg_rd(REG_STAT, st);
      if (st[STAT_BUSY] === 1'b0) break;
    end
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 30000; i++) begin
      @(posedge clock);
      if (notes.size() == 0) break;
    end
  endtask
  function automatic int exp_len(logic [7:0] c);
    case (c[1:0])
      2'h1: return (c[2] ? T50D : T50N) + 1;
      2'h2: return (c[2] ? T60D : T60N) + 1;
      default: return (c[2] ? TDUD : TDUN) + 1;
    endcase
  endfunction
  // ----------------------------------------
  // Clock, external conversion clock, result monitor
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (nrst !== 1'b1) begin
      div <= 5'h0;
      ckpin <= 1'b0;
      prev_conv <= 1'b0;
      run_len <= 32'h0;
    end else begin
      div <= div + 5'h1;
      ckpin <= ext_run & div[4];
      prev_conv <= converting;
      if (converting === 1'b1) run_len <= (prev_conv === 1'b1) ? run_len + 32'h1 : 32'h1;
    end
  end
  initial forever begin
    @(posedge clock);
    if (conv_done === 1'b1) begin
      repeat (2) @(posedge clock);
      #1;
      if (notes.size() == 0) check("extra_conversion", 32'h1, 32'h0);
      else begin
        note = notes.pop_front();
        check("cfg", {24'h0, cfg_active}, {24'h0, note.cfg});
        check("suspect", {31'h0, result_suspect}, {31'h0, note.sus});
        check("valid", {31'h0, result_valid}, 32'h1);
        if (note.len != 0) check("conv_len", run_len, note.len);
      end
    end
  end
  initial begin
    #800000;
    n_errors++;
    test_done;
  end
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    ext_run = 1'b0;
    void'($urandom(32'h7dff));
    hi = 6'($urandom % 32);
    repeat (10) @(posedge clock);
    check("por", {31'h0, por_active}, 32'h1);
    check("cfg_reset", {24'h0, cfg_active}, 32'h0);
    check("int_osc", {31'h0, int_osc_en}, 32'h1);
    notes.push_back(acs_note_s'{8'h0, exp_len(8'h0), 1'b0});
    nrst <= 1'b1;
    reg_rd(8'h10, s);
    check("unmapped", s, 32'h0);
    reg_wr(REG_TARGET, {25'h0, hi, 1'b0});
    frame(32'h1, s);
    check("busy_nack", s, 32'h6);
    wait_idle;
    cfg = {5'h0, 1'($urandom % 2), 2'($urandom % 3)};
    reg_wr(REG_CFG, {24'h0, cfg});
    notes.push_back(acs_note_s'{cfg, exp_len(cfg), 1'b0});
    frame(32'h7, s);
    check("global_ack", s, 32'h4);
    wait_idle;
    @(posedge clock);
    ext_run <= 1'b1;
    repeat (300) @(posedge clock);
    check("ext_seen", {31'h0, ext_clk_active}, 32'h1);
    check("osc_off", {31'h0, int_osc_en}, 32'h0);
    reg_wr(REG_TARGET, {25'h0, hi, 1'b1});
    notes.push_back(acs_note_s'{cfg, 0, 1'b1});
    frame(32'h1, s);
    check("ext_addr_ack", s, 32'h4);
    repeat (8) @(posedge clock);
    check("notch_ext", {31'h0, notch_ext}, 32'h1);
    check("ext_conv", {31'h0, converting}, 32'h1);
    ext_run <= 1'b0;
    wait_idle;
    check("osc_back", {31'h0, int_osc_en}, 32'h1);
    test_done;
  end
endmodule
`default_nettype wire
